// file: lfr_link_recovery.sv
// Link error recovery: frame reject condition, link reset and sequence pointers
`timescale 1ns/1ps
module lfr_link_recovery #(
    parameter logic [lfr_pkg::N2_W-1:0] N2 = lfr_pkg::N2_DEFAULT
) (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic RX_VALID_I,
    input wire lfr_pkg::lfr_frame_type RX_KIND_I,
    input wire logic RX_PF_I,
    input wire logic [lfr_pkg::SEQ_W-1:0] RX_NR_I,
    input wire logic RX_NS_OK_I,
    input wire logic [2:0] RX_VIOL_I,
    input wire logic T1_EXPIRE_I,
    input wire logic [lfr_pkg::TXB_N-1:0] TX_SENT_I,
    input wire logic TX_PKT_DONE_I,
    input wire logic SEND_SET_I,
    input wire logic MANUAL_DISCONNECT_BIT_I,
    input wire logic RX_ENABLE_BIT_I,
    input wire logic SEG0_READY_I,
    input wire logic NEXT_SEG_READY_I,
    input wire logic TRANSPARENT_RX_MODE_I,
    output logic LINK_UP_O,
    output logic FRMR_COND_O,
    output logic [lfr_pkg::TXB_N-1:0] TX_PEND_O,
    output logic [3:0] FRMR_FIELD_O,
    output logic TX_ENABLE_O,
    output logic PKT_TX_ALLOW_O,
    output logic RX_STORE_O,
    output logic LOCAL_RX_NOT_READY_FLAG_O,
    output logic [lfr_pkg::SEQ_W-1:0] NE_O,
    output logic [lfr_pkg::SEQ_W-1:0] NA_O,
    output logic [lfr_pkg::SEQ_W-1:0] VS_O,
    output logic [lfr_pkg::SEQ_W-1:0] VR_O,
    output logic [lfr_pkg::SEQ_N-1:0] ACK_SET_O,
    output logic ACK_IRQ_O,
    output logic ERR_IRQ_O,
    output logic [7:0] ERR_CODE_O
);
    lfr_pkg::lfr_link_type link_q;
    logic frmr_q;
    logic rx_block_q;
    logic [lfr_pkg::N2_W-1:0] poll_q;
    logic up;
    logic rx;
    logic is_nr;
    logic nr_ok;
    logic unsol;
    logic rx_frmr;
    logic rx_sabm;
    logic rx_disc;
    logic ua_done;
    logic n2_out;
    logic rst_link;
    logic frmr_new;
    logic frmr_again;
    logic rx_ready;
    logic rx_lookup_not_ready_irq;
    logic rx_store;
    logic [3:0] reason;

    lfr_seq_if seq ();

    // Window check against oldest unacked and next new packet
    assign seq.na = NA_O;
    assign seq.nb = VS_O;
    assign seq.nr = RX_NR_I;
    lfr_nr_check u_nr (
        .seq(seq)
    );

    lfr_rx_ready u_rdy (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .manual_disconnect_bit_i(MANUAL_DISCONNECT_BIT_I),
        .resample_i(ua_done || rx_sabm),
        .rx_enable_bit_i(RX_ENABLE_BIT_I),
        .seg0_ready_i(SEG0_READY_I),
        .next_seg_ready_i(NEXT_SEG_READY_I),
        .rx_event_i(rx && is_nr),
        .ready_o(rx_ready),
        .local_rx_not_ready_flag_o(LOCAL_RX_NOT_READY_FLAG_O),
        .rx_lookup_not_ready_irq_o(rx_lookup_not_ready_irq)
    );

    // Decoded events of the received frame
    assign up = (link_q == lfr_pkg::LNK_UP);
    assign rx = RX_VALID_I;
    assign is_nr = RX_KIND_I inside {lfr_pkg::FR_I, lfr_pkg::FR_S_CMD, lfr_pkg::FR_S_RSP};
    assign nr_ok = seq.valid;
    assign rx_frmr = up && rx && (RX_KIND_I == lfr_pkg::FR_FRMR);
    assign rx_sabm = !MANUAL_DISCONNECT_BIT_I && rx && (RX_KIND_I == lfr_pkg::FR_SABM);
    assign rx_disc = rx && (RX_KIND_I == lfr_pkg::FR_DISC) && (link_q != lfr_pkg::LNK_DOWN);
    assign ua_done = (link_q == lfr_pkg::LNK_RESET) && rx && (RX_KIND_I == lfr_pkg::FR_UA);
    // An F bit with no poll outstanding was never asked for
    assign unsol = rx && ((RX_KIND_I == lfr_pkg::FR_UA)
        || ((RX_KIND_I == lfr_pkg::FR_S_RSP) && RX_PF_I && (poll_q == '0)));
    assign n2_out = up && T1_EXPIRE_I && (poll_q == N2);
    assign rst_link = rx_frmr || n2_out;

    // Reject reasons; W also covers the unsolicited cases
    assign reason[lfr_pkg::RJ_W] = RX_VIOL_I[0] || unsol;
    assign reason[lfr_pkg::RJ_X] = RX_VIOL_I[1];
    assign reason[lfr_pkg::RJ_Y] = RX_VIOL_I[2];
    assign reason[lfr_pkg::RJ_Z] = is_nr && !nr_ok;
    // Only while up; resetting frames outrank a reject
    assign frmr_new = up && rx && !rx_frmr && !rx_sabm && !rx_disc && !n2_out
        && (reason != 4'h0);
    assign frmr_again = frmr_q && rx && is_nr && (reason == 4'h0);

    // I-field admission: FRMR body, or in-sequence packets (any packet in transparent mode) outside the condition
    assign rx_store = rx && rx_ready && !rx_block_q && (rx_frmr
        || (up && !frmr_q && (RX_KIND_I == lfr_pkg::FR_I) && (RX_NS_OK_I || TRANSPARENT_RX_MODE_I)));

    // Link phase; the manual disconnect forces the link down
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            link_q <= lfr_pkg::LNK_DOWN;
        end else if (MANUAL_DISCONNECT_BIT_I) begin
            link_q <= lfr_pkg::LNK_DOWN;
        end else if (rx_sabm) begin
            link_q <= lfr_pkg::LNK_UP;
        end else if (rx_disc) begin
            link_q <= lfr_pkg::LNK_DOWN;
        end else if (rst_link) begin
            link_q <= lfr_pkg::LNK_RESET;
        end else if (ua_done) begin
            link_q <= lfr_pkg::LNK_UP;
        end
    end

    // Frame reject condition; SABM, DISC, a received FRMR or the N2 poll limit ends it while up
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            frmr_q <= 1'b0;
        end else if (rx_sabm || rx_disc || !up) begin
            frmr_q <= 1'b0;
        end else if (frmr_new) begin
            frmr_q <= 1'b1;
        end else if (rst_link) begin
            frmr_q <= 1'b0;
        end
    end

    // Reject field is kept for retransmission, replaced by a new reject
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            FRMR_FIELD_O <= 4'h0;
        end else if (frmr_new) begin
            FRMR_FIELD_O <= reason;
        end
    end

    // Poll counter of S-commands sent without an F response
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            poll_q <= '0;
        end else if (!up || n2_out) begin
            poll_q <= '0;
        end else if (T1_EXPIRE_I) begin
            poll_q <= poll_q + 1'b1;
        end else if (rx && (RX_KIND_I == lfr_pkg::FR_S_RSP) && RX_PF_I) begin
            poll_q <= '0;
        end
    end

    // Pending transmissions; a new request wins over the sent strobe
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            TX_PEND_O <= '0;
        end else begin
            TX_PEND_O[lfr_pkg::TXB_SABM] <= rst_link
                || (TX_PEND_O[lfr_pkg::TXB_SABM] && !TX_SENT_I[lfr_pkg::TXB_SABM]);
            TX_PEND_O[lfr_pkg::TXB_UA] <= rx_sabm || rx_disc
                || (TX_PEND_O[lfr_pkg::TXB_UA] && !TX_SENT_I[lfr_pkg::TXB_UA]);
            // Reject dropped when the link leaves the up phase
            TX_PEND_O[lfr_pkg::TXB_FRMR] <= frmr_new || frmr_again
                || (TX_PEND_O[lfr_pkg::TXB_FRMR] && up && !rst_link && !rx_sabm
                && !rx_disc && !TX_SENT_I[lfr_pkg::TXB_FRMR]);
            TX_PEND_O[lfr_pkg::TXB_SCMD] <= (up && T1_EXPIRE_I && !n2_out)
                || (TX_PEND_O[lfr_pkg::TXB_SCMD] && up && !TX_SENT_I[lfr_pkg::TXB_SCMD]);
        end
    end

    // Send enable: host sets it, any link reset clears it; set wins
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            TX_ENABLE_O <= 1'b0;
        end else if (SEND_SET_I) begin
            TX_ENABLE_O <= 1'b1;
        end else if (rst_link || rx_sabm || ua_done) begin
            TX_ENABLE_O <= 1'b0;
        end
    end

    // New packets only with send enabled, link up and no reject pending
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            PKT_TX_ALLOW_O <= 1'b0;
        end else begin
            PKT_TX_ALLOW_O <= TX_ENABLE_O && up && !frmr_q && !frmr_new;
        end
    end

    // After a received reject no I-field enters until receive is re-readied
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            rx_block_q <= 1'b0;
        end else if (rx_frmr) begin
            rx_block_q <= 1'b1;
        end else if (ua_done || rx_sabm) begin
            rx_block_q <= 1'b0;
        end
    end

    // Oldest unacked moves to a valid N(R), even in the reject condition
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            NA_O <= '0;
        end else if (ua_done || rx_sabm) begin
            NA_O <= '0;
        end else if (up && rx && is_nr && nr_ok) begin
            NA_O <= RX_NR_I;
        end
    end

    // Retransmission is not handled here, so V(S) serves as next new index
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            VS_O <= '0;
        end else if (ua_done || rx_sabm) begin
            VS_O <= '0;
        end else if (TX_PKT_DONE_I && PKT_TX_ALLOW_O) begin
            VS_O <= VS_O + 1'b1;
        end
    end

    // V(R) counts accepted in-sequence packets; NE counts stored I-frames
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            VR_O <= '0;
            NE_O <= '0;
            RX_STORE_O <= 1'b0;
        end else begin
            RX_STORE_O <= rx_store;
            if (ua_done || rx_sabm) begin
                VR_O <= '0;
                NE_O <= '0;
            end else begin
                if (rx_store && (RX_KIND_I == lfr_pkg::FR_I) && RX_NS_OK_I) begin
                    VR_O <= VR_O + 1'b1;
                end
                // A stored reject body stays in the current segment, so NE keeps V(R)
                if (rx_store && (RX_KIND_I == lfr_pkg::FR_I) && (RX_NS_OK_I || TRANSPARENT_RX_MODE_I)) begin
                    NE_O <= NE_O + 1'b1;
                end
            end
        end
    end

    // Acknowledged flags set one pulse per accepted N(R)
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            ACK_SET_O <= '0;
            ACK_IRQ_O <= 1'b0;
        end else begin
            ACK_SET_O <= (up && rx && is_nr) ? seq.ack_mask : '0;
            ACK_IRQ_O <= up && rx && is_nr && (seq.ack_mask != '0);
        end
    end

    // Error reporting; a received reject outranks the other codes
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            ERR_IRQ_O <= 1'b0;
            ERR_CODE_O <= lfr_pkg::ERR_NONE;
        end else begin
            ERR_IRQ_O <= rx_frmr || rx_lookup_not_ready_irq || ua_done || rx_sabm;
            if (rx_frmr) begin
                ERR_CODE_O <= lfr_pkg::ERR_FRMR_RX;
            end else if (ua_done || rx_sabm) begin
                ERR_CODE_O <= (RX_ENABLE_BIT_I && SEG0_READY_I) ? lfr_pkg::ERR_UP_READY
                    : lfr_pkg::ERR_UP_NOT_READY;
            end else if (rx_lookup_not_ready_irq) begin
                ERR_CODE_O <= lfr_pkg::ERR_RX_NOT_READY;
            end
        end
    end

    // Status mirrors
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            LINK_UP_O <= 1'b0;
            FRMR_COND_O <= 1'b0;
        end else begin
            LINK_UP_O <= up;
            FRMR_COND_O <= frmr_q;
        end
    end

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);

    sequence s_frmr_in;
        up && rx && (RX_KIND_I == lfr_pkg::FR_FRMR) && !MANUAL_DISCONNECT_BIT_I;
    endsequence
    sequence s_reset_out;
        TX_PEND_O[lfr_pkg::TXB_SABM] && ERR_IRQ_O && (ERR_CODE_O == lfr_pkg::ERR_FRMR_RX);
    endsequence
    sequence s_reset_sabm;
        (link_q == lfr_pkg::LNK_RESET) && !MANUAL_DISCONNECT_BIT_I && !rx;
    endsequence

    a_frmr_rx_reset: assert property (s_frmr_in ##0 !SEND_SET_I
        |=> s_reset_out ##0 !TX_ENABLE_O) else $error("received FRMR not handled");
    a_reset_then_zero: assert property (s_frmr_in ##1 s_reset_sabm
        ##1 ua_done |=> (NA_O == 3'h0) && (VS_O == 3'h0) && (NE_O == 3'h0)
        && (VR_O == 3'h0)) else $error("pointers not zeroed after reset");
    a_frmr_only_up: assert property (frmr_q |-> up) else $error("reject held while down");
    a_unsol_ua_w: assert property (up && rx && (RX_KIND_I == lfr_pkg::FR_UA)
        && !MANUAL_DISCONNECT_BIT_I |=> TX_PEND_O[lfr_pkg::TXB_FRMR] && FRMR_FIELD_O[lfr_pkg::RJ_W])
        else $error("unsolicited UA without W reject");
    a_hold_packets: assert property (frmr_q |=> !PKT_TX_ALLOW_O)
        else $error("packet allowed in reject condition");
    a_no_store_frmr: assert property (frmr_q && rx && (RX_KIND_I == lfr_pkg::FR_I)
        |=> !RX_STORE_O) else $error("I-field stored in reject condition");
    a_sabm_clears: assert property (frmr_q && rx_sabm |=> !frmr_q && up
        && TX_PEND_O[lfr_pkg::TXB_UA]) else $error("SABM did not clear reject");
    a_disc_down: assert property (frmr_q && rx_disc && !rx_sabm |=> !frmr_q
        && (link_q == lfr_pkg::LNK_DOWN)) else $error("DISC did not clear reject");
    a_frmr_retx: assert property (frmr_again && !MANUAL_DISCONNECT_BIT_I |=> TX_PEND_O[lfr_pkg::TXB_FRMR]
        && (FRMR_FIELD_O == $past(FRMR_FIELD_O))) else $error("reject not repeated");
    a_bad_nr_z: assert property (up && rx && is_nr && !nr_ok && !MANUAL_DISCONNECT_BIT_I
        |=> FRMR_FIELD_O[lfr_pkg::RJ_Z] && frmr_q) else $error("bad N(R) without Z");
    a_ack_in_frmr: assert property (frmr_q && rx && is_nr && nr_ok && (RX_NR_I != NA_O)
        |=> ACK_IRQ_O && (ACK_SET_O != '0)) else $error("ack lost in reject");
    a_n2_reset: assert property (n2_out && !MANUAL_DISCONNECT_BIT_I && !rx
        |=> TX_PEND_O[lfr_pkg::TXB_SABM] && (link_q == lfr_pkg::LNK_RESET))
        else $error("no SABM after N2 polls");
    a_ne_tracks_vr: assert property (!TRANSPARENT_RX_MODE_I && (NE_O == VR_O) && !rx_store
        |=> NE_O == VR_O) else $error("NE drifted from V(R)");
endmodule : lfr_link_recovery

// file: lfr_link_recovery_bench.sv
// Self-checking bench of the link recovery block
`timescale 1ns/1ps
module lfr_link_recovery_bench;
    localparam logic [3:0] N2 = 4'h2;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rxv, pf, nsok, t1, pkt, sset, manual_disconnect_bit, rx_enable_bit, seg0, transparent_rx_mode, up, cond, txen, allow;
    logic store, local_rx_not_ready_flag, ackirq, errirq;
    logic nseg = 1'b1;
    lfr_pkg::lfr_frame_type kind;
    logic [2:0] nr, viol, ne, na, vs, vr;
    logic [3:0] sent, pend, field;
    logic [7:0] ackset, code;
    logic [7:0] err_q[$];
    logic [7:0] ack_q[$];
    int error_cnt = 0;
    int n_checks = 0;
    int n;
    lfr_link_recovery #(.N2(N2)) lfr_link_recovery_inst (.CLOCK_I(clk), .RST_I(rst),
        .RX_VALID_I(rxv), .RX_KIND_I(kind), .RX_PF_I(pf), .RX_NR_I(nr), .RX_NS_OK_I(nsok),
        .RX_VIOL_I(viol), .T1_EXPIRE_I(t1), .TX_SENT_I(sent), .TX_PKT_DONE_I(pkt),
        .SEND_SET_I(sset), .MANUAL_DISCONNECT_BIT_I(manual_disconnect_bit), .RX_ENABLE_BIT_I(rx_enable_bit), .SEG0_READY_I(seg0),
        .NEXT_SEG_READY_I(nseg), .TRANSPARENT_RX_MODE_I(transparent_rx_mode), .LINK_UP_O(up), .FRMR_COND_O(cond),
        .TX_PEND_O(pend), .FRMR_FIELD_O(field), .TX_ENABLE_O(txen), .PKT_TX_ALLOW_O(allow),
        .RX_STORE_O(store), .LOCAL_RX_NOT_READY_FLAG_O(local_rx_not_ready_flag), .NE_O(ne), .NA_O(na), .VS_O(vs), .VR_O(vr),
        .ACK_SET_O(ackset), .ACK_IRQ_O(ackirq), .ERR_IRQ_O(errirq), .ERR_CODE_O(code));
    lfr_remote_station lfr_remote_station_inst (.clk_i(clk), .tx_pend_i(pend),
        .tx_sent_o(sent), .rx_valid_o(rxv), .rx_kind_o(kind), .rx_pf_o(pf), .rx_nr_o(nr),
        .rx_ns_ok_o(nsok), .rx_viol_o(viol));
    // 25 MHz clock
    initial forever #20 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Inputs always move 1 ns after the edge
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step
    task automatic fr(input lfr_pkg::lfr_frame_type k, input logic p, input int r, input int v);
        lfr_remote_station_inst.send(k, p, 3'(r), 3'(v));
    endtask : fr
    // Remote sets up the link; a ready receiver gives code 21
    task automatic link_up();
        err_q.push_back(lfr_pkg::ERR_UP_READY);
        fr(lfr_pkg::FR_SABM, 1'b1, 0, 0);
        chk(8'(pend[1]), 8'h01);
        lfr_remote_station_inst.drain();
        step(1);
        chk(8'({up, cond}), 8'h02);
    endtask : link_up
    task automatic final_report();
        $display("Checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    // Each interrupt takes the oldest expected note; an unexpected one never matches
    always @(posedge clk) begin
        if (errirq === 1'b1) chk(code, err_q.size() ? err_q.pop_front() : 8'hXX);
        if (ackirq === 1'b1) chk(ackset, ack_q.size() ? ack_q.pop_front() : 8'hXX);
        if (transparent_rx_mode === 1'b0) chk({5'h0, ne}, {5'h0, vr});
    end
    // Watchdog far beyond the few hundred cycles the tests need
    initial begin
        #400000;
        error_cnt++;
        final_report();
    end
    // Main sequence
    initial begin
        void'($urandom(73));
        {t1, pkt, sset, manual_disconnect_bit, rx_enable_bit, seg0, transparent_rx_mode} = 7'h04;
        err_q.push_back(lfr_pkg::ERR_RX_NOT_READY);
        step(16);
        rst = 1'b0;
        step(4);
        chk(8'(local_rx_not_ready_flag), 8'h01);
        seg0 = 1'b1;
        step(2);
        chk(8'(local_rx_not_ready_flag), 8'h01);
        fr(lfr_pkg::FR_S_RSP, 1'b0, 0, 0);
        step(1);
        chk(8'(local_rx_not_ready_flag), 8'h00);
        link_up();
        sset = 1'b1;
        step(1);
        sset = 1'b0;
        step(1);
        chk(8'({txen, allow}), 8'h03);
        n = 1 + $urandom_range(2);
        repeat (n) begin
            pkt = 1'b1;
            step(1);
            pkt = 1'b0;
            step(1);
        end
        chk({2'h0, na, vs}, 8'(n));
        fr(lfr_pkg::FR_I, 1'b0, 0, 0);
        chk(8'({store, vr}), 8'h09);
        // Unsolicited UA opens the reject condition
        fr(lfr_pkg::FR_UA, 1'b1, 0, 0);
        chk(8'({pend[2], field}), 8'h11);
        step(2);
        chk(8'({cond, allow}), 8'h02);
        lfr_remote_station_inst.drain();
        fr(lfr_pkg::FR_I, 1'b0, 0, 0);
        chk(8'({store, cond, pend[2], field}), 8'h31);
        lfr_remote_station_inst.drain();
        ack_q.push_back(8'((1 << n) - 1));
        fr(lfr_pkg::FR_S_RSP, 1'b0, n, 0);
        chk(8'({pend[2], na}), 8'(8 + n));
        lfr_remote_station_inst.drain();
        fr(lfr_pkg::FR_S_CMD, 1'b1, n + 1, 0);
        chk(8'({pend[2], field[3]}), 8'h03);
        lfr_remote_station_inst.drain();
        fr(lfr_pkg::FR_I, 1'b0, n, 2);
        chk(8'({pend[2], field[1]}), 8'h03);
        lfr_remote_station_inst.drain();
        fr(lfr_pkg::FR_DISC, 1'b1, 0, 0);
        chk(8'(pend[1]), 8'h01);
        lfr_remote_station_inst.drain();
        chk(8'({up, cond}), 8'h00);
        // Link down: nothing may raise a reject
        for (int i = 0; i < 3; i++) begin
            fr(i == 0 ? lfr_pkg::FR_UA : lfr_pkg::FR_S_RSP, 1'b1, 0, i == 2 ? 1 : 0);
            chk(8'(pend[2]), 8'h00);
        end
        link_up();
        chk(8'(txen), 8'h00);
        fr(lfr_pkg::FR_S_RSP, 1'b1, 0, 0);
        chk(8'({pend[2], field}), 8'h11);
        lfr_remote_station_inst.drain();
        link_up();
        // Received reject resets the link
        sset = 1'b1;
        step(1);
        sset = 1'b0;
        step(1);
        pkt = 1'b1;
        step(1);
        pkt = 1'b0;
        fr(lfr_pkg::FR_I, 1'b0, 0, 0);
        err_q.push_back(lfr_pkg::ERR_FRMR_RX);
        fr(lfr_pkg::FR_FRMR, 1'b0, 0, 0);
        chk(8'({pend[0], txen, store}), 8'h05);
        fr(lfr_pkg::FR_I, 1'b0, 0, 0);
        chk(8'(store), 8'h00);
        lfr_remote_station_inst.drain();
        err_q.push_back(lfr_pkg::ERR_UP_READY);
        fr(lfr_pkg::FR_UA, 1'b0, 0, 0);
        chk({2'h0, ne, na}, 8'h00);
        chk({1'b0, txen, vs, vr}, 8'h00);
        step(2);
        // One answered poll, then N2 silent polls and a reset
        t1 = 1'b1;
        step(1);
        t1 = 1'b0;
        chk(8'(pend[3]), 8'h01);
        lfr_remote_station_inst.drain();
        fr(lfr_pkg::FR_S_RSP, 1'b1, 0, 0);
        chk(8'(pend[2]), 8'h00);
        for (int i = 0; i <= int'(N2); i++) begin
            t1 = 1'b1;
            step(1);
            t1 = 1'b0;
            chk(8'(pend), i < int'(N2) ? 8'h08 : 8'h01);
            lfr_remote_station_inst.drain();
        end
        err_q.push_back(lfr_pkg::ERR_UP_READY);
        fr(lfr_pkg::FR_UA, 1'b0, 0, 0);
        step(2);
        chk(8'(up), 8'h01);
        // Next receive segment not ready while enabled: code 10
        nseg = 1'b0;
        err_q.push_back(lfr_pkg::ERR_RX_NOT_READY);
        step(2);
        chk(8'(local_rx_not_ready_flag), 8'h01);
        nseg = 1'b1;
        // Manual disconnect with receiver disabled: not ready, no interrupt
        manual_disconnect_bit = 1'b1;
        step(3);
        chk(8'(up), 8'h00);
        {rx_enable_bit, seg0, manual_disconnect_bit} = 3'h0;
        step(6);
        chk(8'(local_rx_not_ready_flag), 8'h01);
        chk(8'(err_q.size() + ack_q.size()), 8'h00);
        final_report();
    end
endmodule : lfr_link_recovery_bench

// file: lfr_nr_check.sv
// Circular N(R) validity check and acknowledged-entry mask
`timescale 1ns/1ps
module lfr_nr_check (
    lfr_seq_if.chk seq
);
    logic [lfr_pkg::SEQ_W-1:0] dist_nr;
    logic [lfr_pkg::SEQ_W-1:0] dist_nb;

    // Distances measured from the oldest unacked entry, so wrap is free
    assign dist_nr = seq.nr - seq.na;
    assign dist_nb = seq.nb - seq.na;
    assign seq.valid = (dist_nr <= dist_nb);

    // Entry k is acknowledged when it lies in [na, nr)
    for (genvar k = 0; k < lfr_pkg::SEQ_N; k++) begin : g_ack
        logic [lfr_pkg::SEQ_W-1:0] dist_k;
        assign dist_k = lfr_pkg::SEQ_W'(k) - seq.na;
        assign seq.ack_mask[k] = seq.valid && (dist_k < dist_nr);
    end
endmodule : lfr_nr_check

// file: lfr_pkg.sv
// Shared constants and types of the LAPB frame-reject and link-reset block
package lfr_pkg;
    // Sequence numbers are modulo 8
    localparam int SEQ_W = 3;
    localparam int SEQ_N = 8;
    // Retransmission count default and its counter width
    localparam int N2_W = 4;
    localparam logic [N2_W-1:0] N2_DEFAULT = 4'hA;
    // Bit positions in the pending transmit vector
    localparam int TXB_SABM = 0;
    localparam int TXB_UA = 1;
    localparam int TXB_FRMR = 2;
    localparam int TXB_SCMD = 3;
    localparam int TXB_N = 4;
    // Bit positions in the reject reason field
    localparam int RJ_W = 0;
    localparam int RJ_X = 1;
    localparam int RJ_Y = 2;
    localparam int RJ_Z = 3;
    // Error codes
    localparam logic [7:0] ERR_FRMR_RX = 8'hC0;
    localparam logic [7:0] ERR_RX_NOT_READY = 8'h10;
    localparam logic [7:0] ERR_UP_READY = 8'h21;
    localparam logic [7:0] ERR_UP_NOT_READY = 8'h11;
    localparam logic [7:0] ERR_NONE = 8'h00;
    // Decoded kind of a received frame
    typedef enum logic [2:0] {
        FR_I, FR_S_CMD, FR_S_RSP, FR_SABM, FR_DISC, FR_UA, FR_FRMR, FR_OTHER
    } lfr_frame_type;
    // Link phase
    typedef enum logic [1:0] {LNK_DOWN, LNK_RESET, LNK_UP} lfr_link_type;
endpackage : lfr_pkg

// file: lfr_remote_station.sv
// Remote station model: frames toward the block, taking of its pending frames
`timescale 1ns/1ps
module lfr_remote_station (
    input wire logic clk_i,
    input wire logic [3:0] tx_pend_i,
    output logic [3:0] tx_sent_o,
    output logic rx_valid_o,
    output lfr_pkg::lfr_frame_type rx_kind_o,
    output logic rx_pf_o,
    output logic [2:0] rx_nr_o,
    output logic rx_ns_ok_o,
    output logic [2:0] rx_viol_o
);
    // Quiet line at start
    initial begin
        tx_sent_o = 4'h0;
        rx_valid_o = 1'b0;
        rx_kind_o = lfr_pkg::FR_OTHER;
        {rx_pf_o, rx_nr_o, rx_ns_ok_o, rx_viol_o} = 8'h00;
    end
    // One frame, one cycle of valid; fields turn to junk so stale values are never trusted
    task automatic send(input lfr_pkg::lfr_frame_type k, input logic pf, input logic [2:0] nr,
        input logic [2:0] v);
        rx_kind_o = k;
        {rx_pf_o, rx_nr_o, rx_ns_ok_o, rx_viol_o} = {pf, nr, 1'b1, v};
        rx_valid_o = 1'b1;
        @(posedge clk_i);
        #1;
        rx_valid_o = 1'b0;
        {rx_pf_o, rx_nr_o, rx_ns_ok_o, rx_viol_o} = ~{pf, nr, 1'b1, v};
        rx_kind_o = lfr_pkg::lfr_frame_type'($urandom_range(7));
    endtask : send
    // Takes pending frames by priority, each after one to three cycles
    task automatic drain();
        int b;
        repeat (6) if (tx_pend_i != 4'h0) begin
            b = 0;
            while (!tx_pend_i[b]) b++;
            repeat (1 + $urandom_range(2)) @(posedge clk_i);
            #1;
            tx_sent_o[b] = 1'b1;
            @(posedge clk_i);
            #1;
            tx_sent_o = 4'h0;
        end
    endtask : drain
endmodule : lfr_remote_station

// file: lfr_rx_ready.sv
// Receiver enable sampling and local receiver-not-ready tracking
`timescale 1ns/1ps
module lfr_rx_ready (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic manual_disconnect_bit_i,
    input wire logic resample_i,
    input wire logic rx_enable_bit_i,
    input wire logic seg0_ready_i,
    input wire logic next_seg_ready_i,
    input wire logic rx_event_i,
    output logic ready_o,
    output logic local_rx_not_ready_flag_o,
    output logic rx_lookup_not_ready_irq_o
);
    logic manual_disconnect_bit_q;
    logic sample;
    logic good;

    // Falling manual disconnect starts a sample of the enable bit
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            manual_disconnect_bit_q <= 1'b1;
        end else begin
            manual_disconnect_bit_q <= manual_disconnect_bit_i;
        end
    end
    assign sample = (manual_disconnect_bit_q && !manual_disconnect_bit_i) || resample_i;
    assign good = rx_enable_bit_i && seg0_ready_i;

    // Ready is re-sampled at set-up or reset; it drops when the next segment is not ready and returns on a received I or S frame while enabled with segment 0 ready
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ready_o <= 1'b0;
            local_rx_not_ready_flag_o <= 1'b0;
            rx_lookup_not_ready_irq_o <= 1'b0;
        end else begin
            rx_lookup_not_ready_irq_o <= 1'b0;
            if (sample) begin
                ready_o <= good;
                local_rx_not_ready_flag_o <= !good;
                rx_lookup_not_ready_irq_o <= rx_enable_bit_i && !seg0_ready_i;
            end else if (ready_o && !next_seg_ready_i) begin
                ready_o <= 1'b0;
                local_rx_not_ready_flag_o <= 1'b1;
                rx_lookup_not_ready_irq_o <= rx_enable_bit_i;
            end else if (local_rx_not_ready_flag_o && good && rx_event_i) begin
                ready_o <= 1'b1;
                local_rx_not_ready_flag_o <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_rx_lookup_not_ready_irq_when_enabled: assert property (sample && rx_enable_bit_i && !seg0_ready_i
        |=> rx_lookup_not_ready_irq_o && local_rx_not_ready_flag_o && !ready_o) else $error("no rx_lookup_not_ready_irq on unready segment");
    a_no_rx_lookup_not_ready_irq_disabled: assert property (sample && !rx_enable_bit_i
        |=> !rx_lookup_not_ready_irq_o && local_rx_not_ready_flag_o) else $error("rx_lookup_not_ready_irq raised while receiver disabled");
    a_local_rx_not_ready_flag_needs_frame: assert property (local_rx_not_ready_flag_o && !sample && !rx_event_i
        |=> local_rx_not_ready_flag_o) else $error("local_rx_not_ready_flag cleared without received frame");
endmodule : lfr_rx_ready

// file: lfr_seq_if.sv
// Interface carrying window pointers and the received N(R) check result
`timescale 1ns/1ps
interface lfr_seq_if;
    logic [lfr_pkg::SEQ_W-1:0] na;
    logic [lfr_pkg::SEQ_W-1:0] nb;
    logic [lfr_pkg::SEQ_W-1:0] nr;
    logic valid;
    logic [lfr_pkg::SEQ_N-1:0] ack_mask;
    modport chk (input na, input nb, input nr, output valid, output ack_mask);
    modport top (output na, output nb, output nr, input valid, input ack_mask);
endinterface : lfr_seq_if
